// ==== logic/mdpb_bank.sv ====
// Notes on behaviour
// - Jog speed zero or 80..1000, reset 300
// - Speed display: 0 signed, 1 absolute
// - Edit permission 0/1, default 1, immediate
// - Run mode 0 shut-off on, default 1
// - Brake at alarm: 0 after coast, 1 immediate
// - Startup alarm inhibit 0 disabled, default 0
// - Initial view codes 0..4, default 0
// - Analog select 0..2, default 1, steers data
// - Select 0: every number fully digital
// - Select 1: only number 0 speed analog
// - Select 2: all torque limits analog
// - Timeout 0..10000 ms; error count 1..10, 3
// - Immediate entries act right after write
// - Thermal detect acts after configuration only
`timescale 1ns/1ps
`default_nettype none
`include "mdpb_consts.svh"

module mdpb_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [15:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic cfg_exec,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_err,
  output logic rsp_write,
  output logic cfg_pending,
  output logic [31:0] jog_speed,
  output logic [31:0] jog_torque,
  output logic [31:0] setter_speed_display,
  output logic [31:0] setter_edit_enable,
  output logic [31:0] run_mode_select,
  output logic [31:0] brake_on_alarm,
  output logic [31:0] inhibit_on_startup_alarm,
  output logic [31:0] startup_thermal_detect,
  output logic [31:0] setter_initial_view,
  output logic [31:0] analog_source_select,
  output logic [31:0] link_timeout,
  output logic [31:0] link_error_limit,
  output logic [15:0] speed_from_analog,
  output logic [15:0] torque_from_analog
);
  import mdpb_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  // Twelve entries, one flop word each
  localparam int NUM_ENT = 12; // Entry count

  mdpb_state_t state_q; // Engine state
  mdpb_state_t state_d; // Next engine state
  logic [15:0] code_q; // Captured command code
  logic [31:0] wdata_q; // Captured write data
  logic [31:0] store_q [NUM_ENT]; // Stored values
  logic [31:0] therm_eff_q; // Thermal value in force
  logic [31:0] rdata_q; // Answer data
  logic err_q; // Answer error flag
  logic write_q; // Answer was a write
  logic hit; // Code names an entry
  logic is_wr; // Code is a write code
  mdpb_entry_t idx; // Addressed entry
  logic take; // Command accepted now
  logic do_write; // Store update this cycle
  logic [4:0] ent_sel; // Lookup result, hit flag on top

  // Write candidate and its verdict travel together
  mdpb_chk_if chk (); // Range check link

  // ****************************************
  // Helper functions
  // ****************************************

  // Base read code of a command
  // Clearing the offset bit folds both codes together
  function automatic logic [15:0] base_code(logic [15:0] c);
    return c & ~`MDPB_WR_OFS;
  endfunction

  // Write codes carry the offset bit
  function automatic logic wr_code(logic [15:0] c);
    return (c & `MDPB_WR_OFS) != 16'h0000;
  endfunction

  // Map a read code to its entry
  // Top bit flags a hit; low bits give the entry
  function automatic logic [4:0] lookup(logic [15:0] c);
    logic [4:0] r;
    r = 5'h00;
    case (base_code(c))
      `MDPB_CODE_JOG_SPEED: r = {1'b1, ENT_JOG_SPEED};
      `MDPB_CODE_SPD_DISP: r = {1'b1, ENT_SPD_DISP};
      `MDPB_CODE_EDIT_EN: r = {1'b1, ENT_EDIT_EN};
      `MDPB_CODE_RUN_MODE: r = {1'b1, ENT_RUN_MODE};
      `MDPB_CODE_JOG_TORQ: r = {1'b1, ENT_JOG_TORQ};
      `MDPB_CODE_BRAKE: r = {1'b1, ENT_BRAKE};
      `MDPB_CODE_INHIBIT: r = {1'b1, ENT_INHIBIT};
      `MDPB_CODE_THERMAL: r = {1'b1, ENT_THERMAL};
      `MDPB_CODE_VIEW: r = {1'b1, ENT_VIEW};
      `MDPB_CODE_ANALOG: r = {1'b1, ENT_ANALOG};
      `MDPB_CODE_TIMEOUT: r = {1'b1, ENT_TIMEOUT};
      `MDPB_CODE_ERR_LIM: r = {1'b1, ENT_ERR_LIM};
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // Power-up value of each entry
  function automatic logic [31:0] rst_val(logic [3:0] i);
    logic [31:0] r;
    r = 32'h00000000;
    case (i)
      ENT_JOG_SPEED: r = `MDPB_RST_JOG_SPEED;
      ENT_SPD_DISP: r = `MDPB_RST_SPD_DISP;
      ENT_EDIT_EN: r = `MDPB_RST_EDIT_EN;
      ENT_RUN_MODE: r = `MDPB_RST_RUN_MODE;
      ENT_JOG_TORQ: r = `MDPB_RST_JOG_TORQ;
      ENT_BRAKE: r = `MDPB_RST_BRAKE;
      ENT_INHIBIT: r = `MDPB_RST_INHIBIT;
      ENT_THERMAL: r = `MDPB_RST_THERMAL;
      ENT_VIEW: r = `MDPB_RST_VIEW;
      ENT_ANALOG: r = `MDPB_RST_ANALOG;
      ENT_TIMEOUT: r = `MDPB_RST_TIMEOUT;
      ENT_ERR_LIM: r = `MDPB_RST_ERR_LIM;
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // ****************************************
  // Command decode
  // ****************************************

  // Decode the captured code
  // Lookup runs once; its top bit marks a known code
  // Unknown codes leave idx at entry zero, never stored
  always_comb begin
    ent_sel = lookup(code_q);
    hit = ent_sel[4];
    idx = mdpb_entry_t'(ent_sel[3:0]);
    is_wr = wr_code(code_q);
  end

  // New command only while idle
  // Ready drops for the execute and answer cycles,
  // so a master that keeps valid up is simply held off
  assign cmd_ready = (state_q == ST_IDLE);
  assign take = cmd_valid && cmd_ready;

  // Range check of the pending write
  // Check sees the captured data, stable in execute
  assign chk.idx = idx;
  assign chk.data = wdata_q;

  mdpb_range_check u_check (
    .chk (chk)
  );

  // Store only known, in-range writes
  assign do_write = (state_q == ST_EXEC) && hit && is_wr &&
    chk.ok;

  // ****************************************
  // Engine state machine
  // ****************************************

  // Next state
  // Three states; the answer always comes two edges
  // after the command is taken
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // Wait for a command
        if (take) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Act on the store
        state_d = ST_RESP;
      end
      ST_RESP: begin
        // Answer for one cycle
        state_d = ST_IDLE;
      end
      default: begin
        // Recover from a stray code
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Command capture
  // ****************************************

  // Hold code and data for the command
  // Bus lines may change once the command is taken,
  // so they are held here for execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 16'h0000;
      wdata_q <= 32'h00000000;
    end else if (take) begin
      code_q <= cmd_code;
      wdata_q <= cmd_wdata;
    end
  end

  // ****************************************
  // Parameter store
  // ****************************************

  // Stored values, indexed by entry
  // One write port; the index comes from the captured
  // code, so a code change on the bus cannot redirect
  // a write already in progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        store_q[i] <= rst_val(4'(i));
      end
    end else if (do_write) begin
      // Rejected writes leave the old value
      store_q[idx] <= wdata_q;
    end
  end

  // ****************************************
  // Configuration-class shadow
  // ****************************************

  // Thermal setting moves into force on config
  // A write landing in the same edge as the config
  // pulse is not copied; it stays pending until the
  // next pulse or a reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_eff_q <= `MDPB_RST_THERMAL;
    end else if (cfg_exec) begin
      therm_eff_q <= store_q[ENT_THERMAL];
    end
  end

  // Stored value still waiting for config
  // Lets the master see that a config step is owed
  assign cfg_pending = (store_q[ENT_THERMAL] != therm_eff_q);

  // ****************************************
  // Response
  // ****************************************

  // Answer data and status
  // Captured during execute so the answer stands
  // unchanged until the next command is answered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
      write_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      write_q <= is_wr;
      if (!hit) begin
        // Unknown code
        rdata_q <= 32'h00000000;
        err_q <= 1'b1;
      end else if (is_wr) begin
        // Echo stored value after the write
        // A rejected write echoes the kept value
        rdata_q <= chk.ok ? wdata_q : store_q[idx];
        err_q <= !chk.ok;
      end else begin
        // Read of the stored value
        rdata_q <= store_q[idx];
        err_q <= 1'b0;
      end
    end
  end

  // Answer strobe
  // Strobe lasts the single answer cycle
  assign rsp_valid = (state_q == ST_RESP);
  assign rsp_rdata = rdata_q;
  assign rsp_err = err_q;
  assign rsp_write = write_q;

  // ****************************************
  // Values in force
  // ****************************************

  // Immediate entries drive straight from store
  // No shadow here: a write is in force from the
  // cycle after execute, as the answer goes out
  assign jog_speed = store_q[ENT_JOG_SPEED];
  assign jog_torque = store_q[ENT_JOG_TORQ];
  assign setter_speed_display = store_q[ENT_SPD_DISP];
  assign setter_edit_enable = store_q[ENT_EDIT_EN];
  assign run_mode_select = store_q[ENT_RUN_MODE];
  assign brake_on_alarm = store_q[ENT_BRAKE];
  assign inhibit_on_startup_alarm = store_q[ENT_INHIBIT];
  assign setter_initial_view = store_q[ENT_VIEW];
  assign analog_source_select = store_q[ENT_ANALOG];
  assign link_timeout = store_q[ENT_TIMEOUT];
  assign link_error_limit = store_q[ENT_ERR_LIM];

  // Thermal detect only from the shadow
  assign startup_thermal_detect = therm_eff_q;

  // ****************************************
  // Analog source mapping
  // ****************************************

  // Per-number source masks from the selection
  // Masks lag the selection by one cycle; users of
  // operation data must allow for that step
  mdpb_analog_map u_analog (
    .clk (clk),
    .rst_n (rst_n),
    .sel (store_q[ENT_ANALOG]),
    .speed_analog (speed_from_analog),
    .torque_analog (torque_from_analog)
  );

endmodule

`default_nettype wire

// ==== shared/mdpb_consts.svh ====
`ifndef MDPB_CONSTS_SVH
`define MDPB_CONSTS_SVH

// ****************************************
// Command codes (read codes)
// ****************************************
`define MDPB_CODE_JOG_SPEED 16'h0143
`define MDPB_CODE_SPD_DISP 16'h01E0
`define MDPB_CODE_EDIT_EN 16'h01E1
`define MDPB_CODE_RUN_MODE 16'h0816
`define MDPB_CODE_JOG_TORQ 16'h0821
`define MDPB_CODE_BRAKE 16'h0840
`define MDPB_CODE_INHIBIT 16'h0841
`define MDPB_CODE_THERMAL 16'h0843
`define MDPB_CODE_VIEW 16'h0870
`define MDPB_CODE_ANALOG 16'h0871
`define MDPB_CODE_TIMEOUT 16'h0900
`define MDPB_CODE_ERR_LIM 16'h0901
// Write code is read code plus this
`define MDPB_WR_OFS 16'h1000

// ****************************************
// Reset values
// ****************************************
`define MDPB_RST_JOG_SPEED 32'h0000012C
`define MDPB_RST_SPD_DISP 32'h00000000
`define MDPB_RST_EDIT_EN 32'h00000001
`define MDPB_RST_RUN_MODE 32'h00000001
`define MDPB_RST_JOG_TORQ 32'h000000C8
`define MDPB_RST_BRAKE 32'h00000001
`define MDPB_RST_INHIBIT 32'h00000000
`define MDPB_RST_THERMAL 32'h00000000
`define MDPB_RST_VIEW 32'h00000000
`define MDPB_RST_ANALOG 32'h00000001
`define MDPB_RST_TIMEOUT 32'h00000000
`define MDPB_RST_ERR_LIM 32'h00000003

// ****************************************
// Permitted ranges
// ****************************************
`define MDPB_JOG_SPD_MIN 32'h00000050
`define MDPB_JOG_SPD_MAX 32'h000003E8
`define MDPB_TORQ_MAX 32'h000000C8
`define MDPB_FLAG_MAX 32'h00000001
`define MDPB_VIEW_MAX 32'h00000004
`define MDPB_ANALOG_MAX 32'h00000002
`define MDPB_TMO_MAX 32'h00002710
`define MDPB_ERR_MIN 32'h00000001
`define MDPB_ERR_MAX 32'h0000000A

// ****************************************
// Analog mapping reset pattern and source masks
// ****************************************
`define MDPB_RST_SPD_ANA 16'h0001
`define MDPB_RST_TRQ_ANA 16'h0000
`define MDPB_ALL_OPS 16'hFFFF
`define MDPB_OP0_ONLY 16'h0001

`endif

// ==== shared/mdpb_pkg.sv ====
package mdpb_pkg;

  // Parameter entries, storage index order
  typedef enum logic [3:0] {
    ENT_JOG_SPEED = 4'h0,
    ENT_SPD_DISP = 4'h1,
    ENT_EDIT_EN = 4'h2,
    ENT_RUN_MODE = 4'h3,
    ENT_JOG_TORQ = 4'h4,
    ENT_BRAKE = 4'h5,
    ENT_INHIBIT = 4'h6,
    ENT_THERMAL = 4'h7,
    ENT_VIEW = 4'h8,
    ENT_ANALOG = 4'h9,
    ENT_TIMEOUT = 4'hA,
    ENT_ERR_LIM = 4'hB
  } mdpb_entry_t;

  // Command engine states, Gray from idle to answer, two bits back to idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b11
  } mdpb_state_t;

  // Analog source selection codes
  typedef enum logic [1:0] {
    ANA_NONE = 2'h0,
    ANA_SPEED = 2'h1,
    ANA_TORQUE = 2'h2
  } mdpb_analog_t;

endpackage

// ==== shared/mdpb_chk_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Range check request and verdict
interface mdpb_chk_if;
  import mdpb_pkg::*;
  mdpb_entry_t idx; // Entry under test
  logic [31:0] data; // Candidate value
  logic ok; // Value lies in range
  modport req (output idx, output data, input ok);
  modport chk (input idx, input data, output ok);
endinterface

`default_nettype wire

// ==== logic/mdpb_range_check.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mdpb_consts.svh"

module mdpb_range_check (
  mdpb_chk_if.chk chk
);
  import mdpb_pkg::*;

  // ****************************************
  // Range table
  // ****************************************
  function automatic logic in_range(mdpb_entry_t i, logic [31:0] v);
    logic r;
    r = 1'b0;
    case (i)
      ENT_JOG_SPEED: r = (v == 32'h0) ||
        (v >= `MDPB_JOG_SPD_MIN && v <= `MDPB_JOG_SPD_MAX);
      ENT_JOG_TORQ: r = (v <= `MDPB_TORQ_MAX);
      ENT_SPD_DISP: r = (v <= `MDPB_FLAG_MAX);
      ENT_EDIT_EN: r = (v <= `MDPB_FLAG_MAX);
      ENT_RUN_MODE: r = (v <= `MDPB_FLAG_MAX);
      ENT_BRAKE: r = (v <= `MDPB_FLAG_MAX);
      ENT_INHIBIT: r = (v <= `MDPB_FLAG_MAX);
      ENT_THERMAL: r = (v <= `MDPB_FLAG_MAX);
      ENT_VIEW: r = (v <= `MDPB_VIEW_MAX);
      ENT_ANALOG: r = (v <= `MDPB_ANALOG_MAX);
      ENT_TIMEOUT: r = (v <= `MDPB_TMO_MAX);
      ENT_ERR_LIM: r = (v >= `MDPB_ERR_MIN) &&
        (v <= `MDPB_ERR_MAX);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Verdict follows the request directly
  assign chk.ok = in_range(chk.idx, chk.data);

endmodule

`default_nettype wire

// ==== logic/mdpb_analog_map.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mdpb_consts.svh"

module mdpb_analog_map (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] sel,
  output logic [15:0] speed_analog,
  output logic [15:0] torque_analog
);
  import mdpb_pkg::*;

  logic [15:0] spd_d; // Next speed source mask
  logic [15:0] trq_d; // Next torque source mask

  // ****************************************
  // Source selection per operation number
  // ****************************************
  always_comb begin
    spd_d = 16'h0000;
    trq_d = 16'h0000;
    case (sel[1:0])
      ANA_NONE: begin
        // All numbers digital
        spd_d = 16'h0000;
        trq_d = 16'h0000;
      end
      ANA_SPEED: begin
        // Only speed of number 0 analog
        spd_d = `MDPB_OP0_ONLY;
      end
      ANA_TORQUE: begin
        // Torque limit analog everywhere
        trq_d = `MDPB_ALL_OPS;
      end
      default: begin
        // Unreachable codes stay digital
        spd_d = 16'h0000;
        trq_d = 16'h0000;
      end
    endcase
  end

  // Registered masks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_analog <= `MDPB_RST_SPD_ANA;
      torque_analog <= `MDPB_RST_TRQ_ANA;
    end else begin
      speed_analog <= spd_d;
      torque_analog <= trq_d;
    end
  end

endmodule

`default_nettype wire

// ==== tb/mdpb_bank_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ***************************************
// Port checker for the parameter bank
// ***************************************
module mdpb_bank_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [15:0] cmd_code,
  input wire logic cfg_exec,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic rsp_err,
  input wire logic rsp_write,
  input wire logic [31:0] jog_speed,
  input wire logic [31:0] setter_speed_display,
  input wire logic [31:0] setter_edit_enable,
  input wire logic [31:0] run_mode_select,
  input wire logic [31:0] brake_on_alarm,
  input wire logic [31:0] startup_thermal_detect,
  input wire logic [31:0] setter_initial_view,
  input wire logic [31:0] analog_source_select,
  input wire logic [31:0] link_timeout,
  input wire logic [31:0] link_error_limit,
  input wire logic [15:0] speed_from_analog,
  input wire logic [15:0] torque_from_analog
);
  // One clock domain, reset disables all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_rsp_latency: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready ##1 rsp_valid)
    else $error("answer not two cycles after command");
  a_jog_range: assert property (
    jog_speed == 0 || (jog_speed >= 32'h50 && jog_speed <= 32'h3E8))
    else $error("jog speed outside its range");
  a_flag_values: assert property (
    setter_speed_display <= 1 && setter_edit_enable <= 1 &&
    run_mode_select <= 1 && brake_on_alarm <= 1)
    else $error("flag entry holds more than one");
  a_view_range: assert property (
    setter_initial_view <= 32'h4)
    else $error("initial view code above four");
  a_link_ranges: assert property (
    link_timeout <= 32'h2710 && link_error_limit >= 1 &&
    link_error_limit <= 32'hA)
    else $error("link entry outside its range");
  a_speed_map: assert property (
    speed_from_analog ==
    ($past(analog_source_select) == 1 ? 16'h0001 : 16'h0000))
    else $error("speed source mask wrong");
  a_torque_map: assert property (
    torque_from_analog ==
    ($past(analog_source_select) == 2 ? 16'hFFFF : 16'h0000))
    else $error("torque source mask wrong");
  a_thermal_hold: assert property (
    !cfg_exec |=> $stable(startup_thermal_detect))
    else $error("thermal value moved without configuration");
  a_write_applies: assert property (
    rsp_valid && rsp_write && $past(cmd_code, 2) == 16'h11E1
    |-> setter_edit_enable == rsp_rdata)
    else $error("edit permission not in force at answer");
  a_reject_keeps: assert property (
    rsp_valid && rsp_err && $past(cmd_code, 2) == 16'h1143
    |-> jog_speed == rsp_rdata && $stable(jog_speed))
    else $error("rejected write changed jog speed");
  a_unknown_zero: assert property (
    rsp_valid && rsp_err && !rsp_write |-> rsp_rdata == 0)
    else $error("unknown read code returned data");
endmodule

bind mdpb_bank mdpb_bank_monitor i_mdpb_bank_monitor (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cfg_exec(cfg_exec),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
  .rsp_write(rsp_write), .jog_speed(jog_speed),
  .setter_speed_display(setter_speed_display),
  .setter_edit_enable(setter_edit_enable),
  .run_mode_select(run_mode_select), .brake_on_alarm(brake_on_alarm),
  .startup_thermal_detect(startup_thermal_detect),
  .setter_initial_view(setter_initial_view),
  .analog_source_select(analog_source_select),
  .link_timeout(link_timeout), .link_error_limit(link_error_limit),
  .speed_from_analog(speed_from_analog),
  .torque_from_analog(torque_from_analog));

`default_nettype wire

// ==== tb/mdpb_master.sv ====
`timescale 1ns/1ps
`default_nettype none

// ***************************************
// Serial link master, command level
// ***************************************
module mdpb_master (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic rsp_err,
  input wire logic rsp_write,
  output logic cmd_valid,
  output logic [15:0] cmd_code,
  output logic [31:0] cmd_wdata
);
  // Idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 16'h0000;
    cmd_wdata = 32'h00000000;
  end

  // One command: hold until taken, then await the answer
  task automatic send(input logic [15:0] c, input logic [31:0] d,
                      output logic [31:0] rd, output logic er,
                      output logic wr, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h00000000;
    er = 1'b0;
    wr = 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20);
    @(posedge clk);
    // Released lines show the inverse, not stale values
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    for (n = 0; n < 6 && !ok; n++) begin
      @(negedge clk);
      if (rsp_valid === 1'b1) begin
        ok = 1'b1;
        rd = rsp_rdata;
        er = rsp_err;
        wr = rsp_write;
      end
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_motor_drive_parameter_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module tb_motor_drive_parameter_bank;
  import mdpb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_exec = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_err, rsp_write, cfg_pending;
  logic [15:0] cmd_code, speed_from_analog, torque_from_analog;
  logic [31:0] cmd_wdata, rsp_rdata, jog_speed, jog_torque, spd_disp;
  logic [31:0] edit_en, run_mode, brake, inhibit, thermal, view, analog;
  logic [31:0] link_timeout, link_error_limit;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  mdpb_bank i_mdpb_bank (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cfg_exec(cfg_exec), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_err(rsp_err), .rsp_write(rsp_write), .cfg_pending(cfg_pending),
    .jog_speed(jog_speed), .jog_torque(jog_torque),
    .setter_speed_display(spd_disp), .setter_edit_enable(edit_en),
    .run_mode_select(run_mode), .brake_on_alarm(brake),
    .inhibit_on_startup_alarm(inhibit), .startup_thermal_detect(thermal),
    .setter_initial_view(view), .analog_source_select(analog),
    .link_timeout(link_timeout), .link_error_limit(link_error_limit),
    .speed_from_analog(speed_from_analog),
    .torque_from_analog(torque_from_analog));

  mdpb_master i_mdpb_master (.clk(clk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .rsp_write(rsp_write), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata));

  // Verdict and end of run
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  // One command with expected answer
  task automatic cmd(input logic [15:0] c, input logic [31:0] d,
                     input logic e_err, input logic [31:0] e_rd);
    logic [31:0] rd;
    logic er, wr, ok;
    i_mdpb_master.send(c, d, rd, er, wr, ok);
    `CHK(ok, 1'b1)
    `CHK(er, e_err)
    `CHK(rd, e_rd)
    `CHK(wr, c[12])
  endtask

  // Power-up values of every entry
  task automatic t_defaults;
    logic [15:0] rc [12] = '{16'h0143, 16'h01E0, 16'h01E1, 16'h0816,
      16'h0821, 16'h0840, 16'h0841, 16'h0843, 16'h0870, 16'h0871,
      16'h0900, 16'h0901};
    logic [31:0] rv [12] = '{32'h12C, 0, 1, 1, 32'hC8, 1, 0, 0, 0, 1, 0, 3};
    for (int i = 0; i < 12; i++) begin
      cmd(rc[i], 32'h0, 1'b0, rv[i]);
    end
    `CHK(speed_from_analog, 16'h0001)
    $display("defaults done");
  endtask

  // Range edges: {write code, data, expected read, error}
  task automatic t_ranges;
    logic [48:0] w [18] = '{{16'h1143, 16'h0, 16'h0, 1'b0},
      {16'h1143, 16'h4F, 16'h0, 1'b1}, {16'h1143, 16'h50, 16'h50, 1'b0},
      {16'h1143, 16'h3E8, 16'h3E8, 1'b0}, {16'h1143, 16'h3E9, 16'h3E8, 1'b1},
      {16'h11E0, 16'h1, 16'h1, 1'b0}, {16'h11E0, 16'h2, 16'h1, 1'b1},
      {16'h1816, 16'h0, 16'h0, 1'b0}, {16'h1816, 16'h2, 16'h0, 1'b1},
      {16'h1840, 16'h0, 16'h0, 1'b0}, {16'h1841, 16'h2, 16'h0, 1'b1},
      {16'h1870, 16'h4, 16'h4, 1'b0}, {16'h1870, 16'h5, 16'h4, 1'b1},
      {16'h1900, 16'h2710, 16'h2710, 1'b0},
      {16'h1900, 16'h2711, 16'h2710, 1'b1},
      {16'h1901, 16'h0, 16'h3, 1'b1}, {16'h1901, 16'hA, 16'hA, 1'b0},
      {16'h1901, 16'hB, 16'hA, 1'b1}};
    for (int i = 0; i < 18; i++) begin
      cmd(w[i][48:33], {16'h0, w[i][32:17]}, w[i][0],
          {16'h0, w[i][16:1]});
    end
    `CHK(jog_speed, 32'h3E8)
    `CHK(spd_disp, 32'h1)
    `CHK(run_mode, 32'h0)
    `CHK(brake, 32'h0)
    `CHK(view, 32'h4)
    `CHK(link_timeout, 32'h2710)
    $display("ranges done");
  endtask

  // Immediate effect and unknown codes
  task t_immediate;
    cmd(16'h11E1, 32'h0, 1'b0, 32'h0);
    `CHK(edit_en, 32'h0)
    cmd(16'h1901, 32'h5, 1'b0, 32'h5);
    `CHK(link_error_limit, 32'h5)
    cmd(16'h0144, 32'h0, 1'b1, 32'h0);
    cmd(16'h1144, 32'h5, 1'b1, 32'h0);
    cmd(16'h1821, 32'h64, 1'b0, 32'h64);
    `CHK(jog_torque, 32'h64)
    cmd(16'h1821, 32'hC9, 1'b1, 32'h64);
    `CHK(jog_torque, 32'h64)
    cmd(16'h1841, 32'h1, 1'b0, 32'h1);
    `CHK(inhibit, 32'h1)
    $display("immediate done");
  endtask

  // Thermal entry waits for configuration
  task t_thermal;
    cmd(16'h1843, 32'h1, 1'b0, 32'h1);
    `CHK(thermal, 32'h0)
    `CHK(cfg_pending, 1'b1)
    @(posedge clk);
    cfg_exec <= 1'b1;
    @(posedge clk);
    cfg_exec <= 1'b0;
    @(negedge clk);
    `CHK(thermal, 32'h1)
    `CHK(cfg_pending, 1'b0)
    $display("thermal done");
  endtask

  // Every analog source code and one illegal code
  task t_analog;
    for (int s = 0; s < 3; s++) begin
      cmd(16'h1871, s, 1'b0, s);
      @(negedge clk);
      `CHK(speed_from_analog, s == 1 ? 16'h0001 : 16'h0000)
      `CHK(torque_from_analog, s == 2 ? 16'hFFFF : 16'h0000)
    end
    cmd(16'h1871, 32'h3, 1'b1, 32'h2);
    $display("analog done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_ranges();
    t_immediate();
    t_thermal();
    t_analog();
    end_of_test();
  end
endmodule

`default_nettype wire
